//--- logic/stseq_top.sv
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/10ps
// Summary of operation
// R1 - Hold power-on reset until external and core supplies are both valid.
// R2 - After power-on reset, hold system reset until oscillators stable, then start.
// R3 - Main and peripheral clocks run at 8 MHz after reset release.
// R4 - Peripheral clocks gated off by default except processor, memories, ports.
// R5 - Indicator pull-up off during reset, on when start-up begins.
// R6 - On master reset only, write self-loop trap at hard-fault vector slot.
// R7 - Start-up scratch area is 2000_00c0 up to 2000_0200.
// R8 - Setup word bit31 clear: copy bits 19..0 into clock control register.
// R9 - Gate word bit31 clear: copy bits 10..0 into gate-clear register.
// R10 - Word with bit31 set leaves its register unchanged.
// R11 - Integer divider from setup word clamped to range 1..16.
// R12 - Record last reset cause; software clears it via clear register.
// R13 - Software write or watchdog time-out triggers system reset.
// R14 - ECC or parity error trigger system reset when enabled.
// R15 - Start-up reads boot mode index and selects start-up mode.
// R16 - Both clock words applied before control passes to start-up mode.
// R17 - Indicator pull-up stays on from start-up until next reset.
module stseq_top
  import stseq_pkg::*;
#(
  parameter int CLK_W  = STSEQ_CLK_W,
  parameter int GATE_W = STSEQ_GATE_W
)(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  input  wire logic                ext_supply_ok,
  input  wire logic                core_supply_ok,
  input  wire logic                osc_stable,
  input  wire logic                wdt_timeout,
  input  wire logic                ecc_error,
  input  wire logic                parity_error,
  input  wire logic [31:0]         clock_setup_word,
  input  wire logic [31:0]         clock_gate_word,
  input  wire logic [15:0]         boot_mode_index,
  output logic                     por_active,
  output logic                     sys_reset_active,
  output logic                     indicator_pullup,
  output stseq_mem_req_t           mem_req,
  output logic [CLK_W-1:0]         clock_control_reg,
  output logic [GATE_W-1:0]        gate_off,
  output logic [15:0]              boot_mode,
  output logic                     start_user,
  output logic                     irq
);

  // Two-flop synchronisers for pins from other domains
  logic [5:0] sync1;
  logic [5:0] sync2;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
    end
    else
    begin
      sync1 <= {parity_error, ecc_error, wdt_timeout, osc_stable, core_supply_ok,
                ext_supply_ok};
      sync2 <= sync1;
    end
  end
  logic ext_ok, core_ok, osc_ok, wdt_s, ecc_s, par_s;
  assign {par_s, ecc_s, wdt_s, osc_ok, core_ok, ext_ok} = sync2;

  function automatic logic [7:0] clamp_div(input logic [7:0] d);
    if (d < STSEQ_INTEGER_DIVIDER_MIN)
      clamp_div = STSEQ_INTEGER_DIVIDER_MIN;
    else if (d > STSEQ_INTEGER_DIVIDER_MAX)
      clamp_div = STSEQ_INTEGER_DIVIDER_MAX;
    else
      clamp_div = d;
  endfunction

  stseq_state_t        state, next_state;
  logic                master, next_master;
  logic [CLK_W-1:0]    next_clkcr;
  logic [GATE_W-1:0]   next_gate;
  logic [STSEQ_RC_W-1:0] cause, next_cause;
  logic [1:0]          rstcfg, next_rstcfg;
  logic [STSEQ_IRQ_W-1:0] irq_st, next_irq_st, irq_msk, next_irq_msk;
  logic [15:0]         next_boot_mode;
  logic [31:0]         next_prdata;
  logic                next_pslverr;
  logic                sys_trig;
  logic                wr, rd;
  logic [7:0]          off;
  logic [CLK_W-1:0]    setup_word;

  assign pready = 1'b1;
  assign wr     = psel && penable && pwrite;
  assign rd     = psel && !penable && !pwrite;
  assign off    = paddr[7:0];

  // Reset sources
  always_comb
  begin
    sys_trig = wdt_s;
    // R13 software and watchdog
    if (wr && off == STSEQ_OFF_SWRST && pwdata == STSEQ_SWRST_KEY)
      sys_trig = 1'b1;
    // R14 gated error resets
    if ((ecc_s && rstcfg[STSEQ_CFG_ECC]) || (par_s && rstcfg[STSEQ_CFG_PAR]))
      sys_trig = 1'b1;
  end

  always_comb
  begin
    setup_word = clock_setup_word[CLK_W-1:0];
    // R11 divider clamp
    setup_word[STSEQ_INTEGER_DIVIDER_LSB +: STSEQ_INTEGER_DIVIDER_W] =
      clamp_div(clock_setup_word[STSEQ_INTEGER_DIVIDER_LSB +: STSEQ_INTEGER_DIVIDER_W]);
  end

  always_comb
  begin
    next_state     = state;
    next_master    = master;
    next_clkcr     = clock_control_reg;
    next_gate      = gate_off;
    next_boot_mode = boot_mode;
    mem_req        = '0;
    case (state)
      // R1 supplies validated
      ST_POR:
        if (ext_ok && core_ok)
          next_state = ST_SYSRST;
      // R2 wait for oscillators
      ST_SYSRST:
        if (osc_ok)
          next_state = master ? ST_TRAP : ST_SCR;
      // R6 trap on master reset only
      ST_TRAP:
      begin
        mem_req     = '{req: 1'b1, we: 1'b1, addr: STSEQ_HF_VEC, wdata: STSEQ_TRAP_INSN};
        next_master = 1'b0;
        next_state  = ST_SCR;
      end
      // R7 claim scratch area
      ST_SCR:
      begin
        mem_req    = '{req: 1'b1, we: 1'b1, addr: STSEQ_SCR_LO, wdata: 32'h00000000};
        next_state = ST_CLK1;
      end
      ST_CLK1:
      begin
        // R8 R10 setup word
        if (!clock_setup_word[STSEQ_CFG_VALID])
          next_clkcr = setup_word;
        next_state = ST_CLK2;
      end
      ST_CLK2:
      begin
        // R9 R10 gate word
        if (!clock_gate_word[STSEQ_CFG_VALID])
          next_gate = gate_off & ~clock_gate_word[GATE_W-1:0];
        next_state = ST_BMI;
      end
      // R15 boot mode read
      ST_BMI:
      begin
        mem_req        = '{req: 1'b1, we: 1'b0, addr: STSEQ_BMI_ADDR, wdata: 32'h00000000};
        next_boot_mode = boot_mode_index;
        next_state     = ST_RUN;
      end
      ST_RUN:
      begin
        if (wr && off == STSEQ_OFF_CLKCR)
          next_clkcr = pwdata[CLK_W-1:0];
        if (wr && off == STSEQ_OFF_GATE)
          next_gate = pwdata[GATE_W-1:0];
        if (wr && off == STSEQ_OFF_GCLR)
          next_gate = gate_off & ~pwdata[GATE_W-1:0];
        if (wr && off == STSEQ_OFF_GSET)
          next_gate = gate_off | pwdata[GATE_W-1:0];
      end
      default:
        next_state = ST_POR;
    endcase
    if (sys_trig)
    begin
      next_state = ST_SYSRST;
      // R3 R4 defaults restored
      next_clkcr = STSEQ_CLKCR_RST;
      next_gate  = STSEQ_GATE_RST;
    end
  end

  // Registers, interrupts, APB read data
  always_comb
  begin
    next_cause   = cause;
    next_rstcfg  = rstcfg;
    next_irq_st  = irq_st;
    next_irq_msk = irq_msk;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    // R12 clear then record, cause wins
    if (wr && off == STSEQ_OFF_RSTCLR)
      next_cause = cause & ~pwdata[STSEQ_RC_W-1:0];
    if (wr && off == STSEQ_OFF_RSTCFG)
      next_rstcfg = pwdata[1:0];
    if (wr && off == STSEQ_OFF_IRQMSK)
      next_irq_msk = pwdata[STSEQ_IRQ_W-1:0];
    if (wr && off == STSEQ_OFF_IRQST)
      next_irq_st = irq_st & ~pwdata[STSEQ_IRQ_W-1:0];
    if (sys_trig)
    begin
      next_cause = '0;
      next_cause[STSEQ_RC_WDT] = wdt_s;
      next_cause[STSEQ_RC_SW]  = wr && off == STSEQ_OFF_SWRST;
      next_cause[STSEQ_RC_ECC] = ecc_s && rstcfg[STSEQ_CFG_ECC];
      next_cause[STSEQ_RC_PAR] = par_s && rstcfg[STSEQ_CFG_PAR];
      next_irq_st[STSEQ_EV_RST] = 1'b1;
    end
    if (state == ST_BMI)
      next_irq_st[STSEQ_EV_DONE] = 1'b1;
    if (rd)
    begin
      case (off)
        STSEQ_OFF_CLKCR:    next_prdata = 32'(clock_control_reg);
        STSEQ_OFF_GATE:     next_prdata = 32'(gate_off);
        STSEQ_OFF_RSTCAUSE: next_prdata = 32'(cause);
        STSEQ_OFF_RSTCFG:   next_prdata = 32'(rstcfg);
        STSEQ_OFF_STATUS:   next_prdata = 32'(state);
        STSEQ_OFF_IRQST:    next_prdata = 32'(irq_st);
        STSEQ_OFF_IRQMSK:   next_prdata = 32'(irq_msk);
        STSEQ_OFF_BOOTMODE: next_prdata = 32'(boot_mode);
        STSEQ_OFF_GCLR, STSEQ_OFF_GSET, STSEQ_OFF_RSTCLR, STSEQ_OFF_SWRST:
                            next_prdata = 32'h00000000;
        default:
        begin
          next_prdata  = 32'h00000000;
          next_pslverr = 1'b1;
        end
      endcase
    end
    else if (psel && !penable && pwrite && off > STSEQ_OFF_BOOTMODE)
      next_pslverr = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state             <= ST_POR;
      master            <= 1'b1;
      clock_control_reg <= STSEQ_CLKCR_RST;
      gate_off          <= STSEQ_GATE_RST;
      boot_mode         <= 16'h0000;
      cause             <= 5'h01;
      rstcfg            <= 2'h0;
      irq_st            <= 2'h0;
      irq_msk           <= 2'h0;
      prdata            <= 32'h00000000;
      pslverr           <= 1'b0;
    end
    else
    begin
      state             <= next_state;
      master            <= next_master;
      clock_control_reg <= next_clkcr;
      gate_off          <= next_gate;
      boot_mode         <= next_boot_mode;
      cause             <= next_cause;
      rstcfg            <= next_rstcfg;
      irq_st            <= next_irq_st;
      irq_msk           <= next_irq_msk;
      prdata            <= next_prdata;
      pslverr           <= next_pslverr;
    end
  end

  assign por_active       = (state == ST_POR);
  assign sys_reset_active = (state == ST_POR) || (state == ST_SYSRST);
  // R5 R17 pull-up follows reset
  assign indicator_pullup = !sys_reset_active;
  // R16 hand-over after clocks applied
  assign start_user       = (state == ST_RUN);
  assign irq              = |(irq_st & irq_msk);

  property p_por_hold;
    @(posedge pclk) disable iff (!presetn)
      (state == ST_POR && !(ext_ok && core_ok)) |=> state == ST_POR;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("por released early"); // R1

  property p_osc_wait;
    @(posedge pclk) disable iff (!presetn)
      (state == ST_SYSRST && !osc_ok && !sys_trig) |=> sys_reset_active;
  endproperty
  a_osc_wait: assert property (p_osc_wait) else $error("sysrst released early"); // R2

  // Only a reset source may take the pull-up away again
  property p_pullup;
    @(posedge pclk) disable iff (!presetn)
      (indicator_pullup && !sys_trig) |=> indicator_pullup;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pullup dropped"); // R17

  property p_clamp;
    @(posedge pclk) disable iff (!presetn)
      (state == ST_CLK1 && !clock_setup_word[STSEQ_CFG_VALID] && !sys_trig) |=>
        clock_control_reg[STSEQ_INTEGER_DIVIDER_LSB +: STSEQ_INTEGER_DIVIDER_W] inside
          {[STSEQ_INTEGER_DIVIDER_MIN:STSEQ_INTEGER_DIVIDER_MAX]};
  endproperty
  a_clamp: assert property (p_clamp) else $error("divider out of range"); // R11

  property p_skip;
    @(posedge pclk) disable iff (!presetn)
      (state == ST_CLK1 && clock_setup_word[STSEQ_CFG_VALID] && !sys_trig) |=>
        $stable(clock_control_reg);
  endproperty
  a_skip: assert property (p_skip) else $error("unprogrammed word applied"); // R10

  property p_handover;
    @(posedge pclk) disable iff (!presetn)
      $rose(start_user) |-> $past(state, 1) == ST_BMI;
  endproperty
  a_handover: assert property (p_handover) else $error("handover skipped"); // R16

  property p_trap;
    @(posedge pclk) disable iff (!presetn)
      (state == ST_TRAP) |-> mem_req.we && mem_req.addr == STSEQ_HF_VEC;
  endproperty
  a_trap: assert property (p_trap) else $error("trap write wrong"); // R6

  property p_wdt;
    @(posedge pclk) disable iff (!presetn)
      wdt_s |=> sys_reset_active && cause[STSEQ_RC_WDT];
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog reset missed"); // R13

endmodule

//--- logic/stseq_pkg.sv
package stseq_pkg;
  // APB register byte offsets
  localparam logic [7:0] STSEQ_OFF_CLKCR    = 8'h00;
  localparam logic [7:0] STSEQ_OFF_GATE     = 8'h04;
  localparam logic [7:0] STSEQ_OFF_GCLR     = 8'h08;
  localparam logic [7:0] STSEQ_OFF_GSET     = 8'h0c;
  localparam logic [7:0] STSEQ_OFF_RSTCAUSE = 8'h10;
  localparam logic [7:0] STSEQ_OFF_RSTCLR   = 8'h14;
  localparam logic [7:0] STSEQ_OFF_RSTCFG   = 8'h18;
  localparam logic [7:0] STSEQ_OFF_SWRST    = 8'h1c;
  localparam logic [7:0] STSEQ_OFF_STATUS   = 8'h20;
  localparam logic [7:0] STSEQ_OFF_IRQST    = 8'h24;
  localparam logic [7:0] STSEQ_OFF_IRQMSK   = 8'h28;
  localparam logic [7:0] STSEQ_OFF_BOOTMODE = 8'h2c;

  // Clock control layout: [19:0] copied; [17:10] integer divider, 8 MHz => div 1
  localparam int          STSEQ_CLK_W      = 20;
  localparam int          STSEQ_INTEGER_DIVIDER_LSB   = 10;
  localparam int          STSEQ_INTEGER_DIVIDER_W     = 8;
  localparam int          STSEQ_GATE_W     = 11;
  localparam int          STSEQ_CFG_VALID  = 31;
  localparam logic [7:0]  STSEQ_INTEGER_DIVIDER_MIN   = 8'h01;
  localparam logic [7:0]  STSEQ_INTEGER_DIVIDER_MAX   = 8'h10;
  localparam logic [19:0] STSEQ_CLKCR_RST  = 20'h00400;
  localparam logic [10:0] STSEQ_GATE_RST   = 11'h7ff;

  // Reset cause bits
  localparam int STSEQ_RC_POR  = 0;
  localparam int STSEQ_RC_SW   = 1;
  localparam int STSEQ_RC_WDT  = 2;
  localparam int STSEQ_RC_ECC  = 3;
  localparam int STSEQ_RC_PAR  = 4;
  localparam int STSEQ_RC_W    = 5;
  // Reset config enables
  localparam int STSEQ_CFG_ECC = 0;
  localparam int STSEQ_CFG_PAR = 1;
  localparam logic [31:0] STSEQ_SWRST_KEY = 32'h00000001;

  // Interrupt events: 0 startup done, 1 system reset seen
  localparam int STSEQ_IRQ_W = 2;
  localparam int STSEQ_EV_DONE = 0;
  localparam int STSEQ_EV_RST  = 1;

  // Start-up memory map
  localparam logic [31:0] STSEQ_HF_VEC     = 32'h2000000c;
  localparam logic [31:0] STSEQ_TRAP_INSN  = 32'h0000e7fe;
  localparam logic [31:0] STSEQ_SCR_LO     = 32'h200000c0;
  localparam logic [31:0] STSEQ_SCR_HI     = 32'h20000200;
  localparam logic [31:0] STSEQ_BMI_ADDR   = 32'h10000e00;

  localparam int STSEQ_CLK_MHZ = 40;
  localparam int STSEQ_MCLK_MHZ = 8;

  typedef enum logic [7:0] {
    ST_POR    = 8'h01,
    ST_SYSRST = 8'h02,
    ST_TRAP   = 8'h04,
    ST_SCR    = 8'h08,
    ST_CLK1   = 8'h10,
    ST_CLK2   = 8'h20,
    ST_BMI    = 8'h40,
    ST_RUN    = 8'h80
  } stseq_state_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } stseq_mem_req_t;
endpackage

//--- verif/stseq_partner.sv
`timescale 1ns/10ps
module stseq_partner
(
  input  wire logic       pclk,
  input  wire logic       power_on,
  input  wire logic [5:0] lag,
  output logic            ext_supply_ok,
  output logic            core_supply_ok,
  output logic            osc_stable
);
  logic [7:0] age;

  // Age saturates so a long run never wraps
  always_ff @(posedge pclk)
  begin
    if (!power_on)
      age <= 8'h00;
    else if (age != 8'hff)
      age <= age + 8'h01;
  end

  // Core rail follows the external one, oscillators last
  assign ext_supply_ok  = power_on && (age >= {2'h0, lag});
  assign core_supply_ok = power_on && (age >= 8'(2 * lag));
  assign osc_stable     = power_on && (age >= 8'(3 * lag));
endmodule

//--- verif/stseq_top_test.sv
`timescale 1ns/10ps
module stseq_top_test;
  import stseq_pkg::*;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0]          paddr, pwdata, prdata, clock_setup_word, clock_gate_word;
  logic                 ext_supply_ok, core_supply_ok, osc_stable;
  logic                 wdt_timeout, ecc_error, parity_error;
  logic [15:0]          boot_mode_index, boot_mode;
  logic                 por_active, sys_reset_active, indicator_pullup, start_user, irq;
  stseq_mem_req_t       mem_req;
  logic [19:0]          clock_control_reg;
  logic [10:0]          gate_off;
  logic                 power_on, snap;
  logic [5:0]           lag;
  logic [1:0]           snap_sel;
  logic [32:0]          expq[$];
  logic [7:0]           dv[6] = '{8'h00, 8'h01, 8'h05, 8'h10, 8'h11, 8'hff};
  int                   failures, checks, traps, scrs, et, es;

  stseq_top stseq_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .ext_supply_ok(ext_supply_ok),
    .core_supply_ok(core_supply_ok), .osc_stable(osc_stable), .wdt_timeout(wdt_timeout),
    .ecc_error(ecc_error), .parity_error(parity_error),
    .clock_setup_word(clock_setup_word), .clock_gate_word(clock_gate_word),
    .boot_mode_index(boot_mode_index), .por_active(por_active),
    .sys_reset_active(sys_reset_active), .indicator_pullup(indicator_pullup),
    .mem_req(mem_req), .clock_control_reg(clock_control_reg), .gate_off(gate_off),
    .boot_mode(boot_mode), .start_user(start_user), .irq(irq));

  stseq_partner stseq_partner_inst (.pclk(pclk), .power_on(power_on), .lag(lag),
    .ext_supply_ok(ext_supply_ok), .core_supply_ok(core_supply_ok),
    .osc_stable(osc_stable));

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h wanted %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Error reads carry no defined data, so only the error bit counts
  always @(posedge pclk)
  begin
    if ((psel & penable & pready & !pwrite) === 1'b1 || snap)
    begin
      if (expq.size() == 0)
        check(33'h0, 33'h1);
      else if (snap)
        check(snap_sel == 2'd0 ? {20'h0, traps[3:0], scrs[3:0], por_active,
          sys_reset_active, indicator_pullup, start_user, irq} :
          snap_sel == 2'd1 ? {13'h0, clock_control_reg} :
          snap_sel == 2'd2 ? {22'h0, gate_off} : {17'h0, boot_mode},
          expq.pop_front());
      else
        check({pslverr, pslverr === 1'b1 ? 32'h0 : prdata}, expq.pop_front());
    end
  end

  always @(posedge pclk)
  begin
    if (mem_req.req === 1'b1 && mem_req.we === 1'b1)
    begin
      if (mem_req.addr === STSEQ_HF_VEC && mem_req.wdata === STSEQ_TRAP_INSN)
        traps++;
      if (mem_req.addr >= STSEQ_SCR_LO && mem_req.addr < STSEQ_SCR_HI)
        scrs++;
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    if (!wr)
      expq.push_back(exp);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      failures++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic look(input logic [1:0] s, input logic [32:0] exp);
    expq.push_back(exp);
    snap <= 1'b1;
    snap_sel <= s;
    @(posedge pclk);
    snap <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [32:0] pins(input logic [4:0] p);
    return {20'h0, et[3:0], es[3:0], p};
  endfunction

  task automatic wait_user();
    int n;
    n = 0;
    while (start_user !== 1'b1 && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400)
    begin
      failures++;
      summarize();
    end
    @(posedge pclk);
  endtask

  function automatic logic [19:0] clk_exp(input logic [31:0] w);
    logic [7:0] d;
    d = w[17:10];
    if (w[31])
      return STSEQ_CLKCR_RST;
    if (d < STSEQ_INTEGER_DIVIDER_MIN)
      d = STSEQ_INTEGER_DIVIDER_MIN;
    if (d > STSEQ_INTEGER_DIVIDER_MAX)
      d = STSEQ_INTEGER_DIVIDER_MAX;
    return {w[19:18], d, w[9:0]};
  endfunction

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, power_on, snap} = '0;
    {wdt_timeout, ecc_error, parity_error, snap_sel, lag} = '0;
    {clock_setup_word, clock_gate_word, boot_mode_index} = '0;
    {failures, checks, traps, scrs, et, es} = '0;
    void'($urandom(32076));
    for (int i = 0; i < 6; i++)
    begin
      clock_setup_word <= {i == 5, 13'($urandom()), dv[i], 10'($urandom())};
      clock_gate_word <= {i == 4, 31'($urandom())};
      boot_mode_index <= 16'($urandom());
      presetn <= 1'b0;
      power_on <= 1'b0;
      lag <= (i % 2 == 1) ? 6'd40 : 6'd12;
      repeat (20) @(posedge pclk);
      look(2'd0, pins(5'b11000));
      look(2'd1, {13'h0, STSEQ_CLKCR_RST});
      look(2'd2, {22'h0, STSEQ_GATE_RST});
      presetn <= 1'b1;
      power_on <= 1'b1;
      repeat (int'(lag) + 6) @(posedge pclk);
      look(2'd0, pins(5'b11000));
      repeat (int'(lag)) @(posedge pclk);
      look(2'd0, pins(5'b01000));
      wait_user();
      et++;
      es++;
      look(2'd0, pins(5'b00110));
      look(2'd1, {13'h0, clk_exp(clock_setup_word)});
      look(2'd2, {22'h0, clock_gate_word[31] ? STSEQ_GATE_RST :
        STSEQ_GATE_RST & ~clock_gate_word[10:0]});
      rd(STSEQ_OFF_BOOTMODE, {16'h0, boot_mode_index});
      look(2'd3, {17'h0, boot_mode_index});
      $display("boot case %0d done", i);
    end
    rd(STSEQ_OFF_STATUS, {24'h0, ST_RUN});
    // Unaligned offset and offset past the last register fall in no register
    apb(1'b0, 8'h02, 32'h0, {1'b1, 32'h0});
    apb(1'b0, 8'h30, 32'h0, {1'b1, 32'h0});
    rd(STSEQ_OFF_RSTCAUSE, 32'h1 << STSEQ_RC_POR);
    wr(STSEQ_OFF_RSTCLR, 32'hffffffff);
    rd(STSEQ_OFF_RSTCAUSE, 32'h0);
    wr(STSEQ_OFF_SWRST, STSEQ_SWRST_KEY);
    repeat (3) @(posedge pclk);
    wait_user();
    es++;
    rd(STSEQ_OFF_RSTCAUSE, 32'h1 << STSEQ_RC_SW);
    look(2'd0, pins(5'b00110));
    // Cases: watchdog, ecc off, parity off, ecc on, parity on
    for (int k = 0; k < 5; k++)
    begin
      wr(STSEQ_OFF_RSTCFG, {30'h0, k == 4, k == 3});
      wr(STSEQ_OFF_RSTCLR, 32'hffffffff);
      wdt_timeout <= (k == 0);
      ecc_error <= (k == 1 || k == 3);
      parity_error <= (k == 2 || k == 4);
      repeat (4) @(posedge pclk);
      {wdt_timeout, ecc_error, parity_error} <= 3'b000;
      repeat (12) @(posedge pclk);
      wait_user();
      // Each real system reset claims the scratch area again
      es += (k == 0 || k > 2) ? 1 : 0;
      rd(STSEQ_OFF_RSTCAUSE, (k == 1 || k == 2) ? 32'h0 : 32'h1 << (k == 0 ?
        STSEQ_RC_WDT : k == 3 ? STSEQ_RC_ECC : STSEQ_RC_PAR));
    end
    $display("reset sources done");
    wr(STSEQ_OFF_IRQMSK, 32'h0);
    rd(STSEQ_OFF_IRQST, 32'h3);
    look(2'd0, pins(5'b00110));
    wr(STSEQ_OFF_IRQMSK, 32'h1 << STSEQ_EV_DONE);
    look(2'd0, pins(5'b00111));
    wr(STSEQ_OFF_IRQST, 32'h1 << STSEQ_EV_DONE);
    look(2'd0, pins(5'b00110));
    rd(STSEQ_OFF_IRQST, 32'h1 << STSEQ_EV_RST);
    $display("interrupt test done");
    wr(STSEQ_OFF_GSET, 32'h000007ff);
    rd(STSEQ_OFF_GATE, 32'h000007ff);
    wr(STSEQ_OFF_GCLR, 32'h00000005);
    rd(STSEQ_OFF_GATE, 32'h000007fa);
    wr(STSEQ_OFF_CLKCR, 32'h00012345);
    look(2'd1, {13'h0, 20'h12345});
    $display("register test done");
    summarize();
  end
endmodule
